// ==== hw/srx_pkg.sv ====
// Shared constants for the subroutine-return execution block
package srx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W   = 13;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  // Literal return: 11 01xx kkkk kkkk, upper four bits decide
  localparam logic [3:0]        LIT_RET_HI   = 4'hd;
  localparam int                LIT_RET_POS  = 10;
  localparam logic [INSN_W-1:0] PLAIN_RET_OP = 14'h0008;
  localparam int                LIT_LSB      = 0;

  // ----------------------------------------------------------------
  // Timing: four phases per instruction cycle, two cycles per return
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_Q1     = 2'h0;
  localparam logic [1:0] PHASE_Q4     = 2'h3;
  localparam int         RET_CYCLES   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST  = 13'h0000;

  typedef enum logic [1:0] {
    SRX_EXEC  = 2'b00,
    SRX_IDLE2 = 2'b01
  } srx_state_type;

endpackage : srx_pkg

// ==== hw/srx_decode.sv ====
// Opcode decoder for the two return instructions
`timescale 1ns/1ps
module srx_decode
  import srx_pkg::*;
(
  input  wire logic [INSN_W-1:0] insn,
  output logic                   is_lit_ret,
  output logic                   is_plain_ret,
  output logic [DATA_W-1:0]      literal
);

  assign is_lit_ret   = (insn[INSN_W-1:LIT_RET_POS] == LIT_RET_HI);
  assign is_plain_ret = (insn == PLAIN_RET_OP);
  assign literal      = insn[LIT_LSB +: DATA_W];

endmodule : srx_decode

// ==== hw/srx_exec.sv ====
// Execution of the literal return and plain return instructions
//
// Operation
// [RULE_01] Literal return writes literal into accumulator
// [RULE_02] Literal return reloads counter from stack top
// [RULE_03] Plain return pops stack, keeps accumulator, flags
// [RULE_04] Plain return takes two cycles, second idle
// [RULE_05] Idle cycle flushes prefetch, fetches return address
`timescale 1ns/1ps
module srx_exec
  import srx_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic [1:0]        PHASE,
  input  wire logic              INSN_VALID,
  input  wire logic [INSN_W-1:0] INSN,
  input  wire logic [PC_W-1:0]   STACK_TOP_ENTRY,
  output logic [DATA_W-1:0]      ACC,
  output logic                   ACC_WE,
  output logic [PC_W-1:0]        PROGRAM_COUNTER,
  output logic                   PC_LOAD,
  output logic                   STACK_POP,
  output logic                   FETCH_FLUSH,
  output logic                   BUSY
);

  logic                is_lit_ret;
  logic                is_plain_ret;
  logic [DATA_W-1:0]   literal;
  srx_state_type       state_q;
  logic                is_lit_q;
  logic                start;
  logic                q1;
  logic                q4;
  logic                pend_q;

  srx_decode u_dec (
    .insn         (INSN),
    .is_lit_ret   (is_lit_ret),
    .is_plain_ret (is_plain_ret),
    .literal      (literal)
  );

  assign q1    = (PHASE == PHASE_Q1);
  assign q4    = (PHASE == PHASE_Q4);
  // Decode sampled at Q1 of the first cycle only
  assign start = (state_q == SRX_EXEC) && q1 && INSN_VALID && (is_lit_ret || is_plain_ret);

  // ----------------------------------------------------------------
  // Cycle sequencing
  // ----------------------------------------------------------------
  // [RULE_04] two-cycle sequence
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q  <= SRX_EXEC;
      is_lit_q <= 1'b0;
    end else begin
      unique case (state_q)
        SRX_EXEC: begin
          if (start) begin
            is_lit_q <= is_lit_ret;
          end
          if (q4 && pend_q) begin
            state_q <= SRX_IDLE2;
          end
        end
        SRX_IDLE2: begin
          if (q4) begin
            state_q  <= SRX_EXEC;
            is_lit_q <= 1'b0;
          end
        end
        default: state_q <= SRX_EXEC;
      endcase
    end
  end

  // Pending flag: a return was decoded in this first cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_q <= 1'b0;
    end else if (start) begin
      pend_q <= 1'b1;
    end else if (q4) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Literal captured at Q1 so a later fetch cannot disturb it
  logic [DATA_W-1:0] lit_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      lit_q <= ACC_RST;
    end else if (start) begin
      lit_q <= literal;
    end
  end

  // [RULE_01] write literal at Q4
  // [RULE_03] plain return leaves accumulator alone
  always_ff @(posedge CLK) begin
    if (RST) begin
      ACC    <= ACC_RST;
      ACC_WE <= 1'b0;
    end else begin
      ACC_WE <= 1'b0;
      if (state_q == SRX_EXEC && pend_q && q4 && is_lit_q) begin
        ACC    <= lit_q;
        ACC_WE <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and stack
  // ----------------------------------------------------------------
  // [RULE_02] load counter from stack top
  // [RULE_03] pop the stack
  always_ff @(posedge CLK) begin
    if (RST) begin
      PROGRAM_COUNTER <= PC_RST;
      PC_LOAD         <= 1'b0;
      STACK_POP       <= 1'b0;
    end else begin
      PC_LOAD   <= 1'b0;
      STACK_POP <= 1'b0;
      if (state_q == SRX_EXEC && pend_q && q4) begin
        PROGRAM_COUNTER <= STACK_TOP_ENTRY;
        PC_LOAD         <= 1'b1;
        STACK_POP       <= 1'b1;
      end
    end
  end

  // [RULE_05] discard prefetch during idle cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      FETCH_FLUSH <= 1'b0;
    end else begin
      FETCH_FLUSH <= (state_q == SRX_EXEC) && pend_q && q4;
    end
  end

  // [RULE_04] busy over both cycles
  always_ff @(posedge CLK) begin
    if (RST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= start || pend_q || (state_q == SRX_IDLE2 && !q4);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_lit_acc;
    @(posedge CLK) disable iff (RST)
      (start && is_lit_ret) |-> ##4 (ACC_WE && (ACC == $past(literal, 4)));
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("literal not written"); // RULE_01

  property p_pc_load;
    @(posedge CLK) disable iff (RST)
      PC_LOAD |-> (PROGRAM_COUNTER == $past(STACK_TOP_ENTRY));
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("counter not from stack"); // RULE_02

  property p_plain_noacc;
    @(posedge CLK) disable iff (RST)
      (start && is_plain_ret) |-> (!ACC_WE) [*5];
  endproperty
  a_plain_noacc: assert property (p_plain_noacc) else $error("plain return wrote acc"); // RULE_03

  property p_pop_pair;
    @(posedge CLK) disable iff (RST)
      PC_LOAD |-> STACK_POP;
  endproperty
  a_pop_pair: assert property (p_pop_pair) else $error("load without pop"); // RULE_03

  property p_idle;
    @(posedge CLK) disable iff (RST)
      (state_q == SRX_IDLE2) && ($past(state_q) == SRX_IDLE2) |->
        (!PC_LOAD && !ACC_WE && !STACK_POP);
  endproperty
  a_idle: assert property (p_idle) else $error("activity in idle cycle"); // RULE_04

  property p_two_cycles;
    @(posedge CLK) disable iff (RST)
      start |-> ##4 (state_q == SRX_IDLE2) ##4 (state_q == SRX_EXEC);
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("not two cycles"); // RULE_04

  property p_flush;
    @(posedge CLK) disable iff (RST)
      PC_LOAD |-> (FETCH_FLUSH && state_q == SRX_IDLE2);
  endproperty
  a_flush: assert property (p_flush) else $error("no flush on return"); // RULE_05

  property p_busy;
    @(posedge CLK) disable iff (RST)
      FETCH_FLUSH |-> BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early"); // RULE_04

  property p_plain_pop;
    @(posedge CLK) disable iff (RST)
      (start && is_plain_ret) |-> ##4 (PC_LOAD && STACK_POP && !ACC_WE);
  endproperty
  a_plain_pop: assert property (p_plain_pop) else $error("plain return did not pop"); // RULE_03

  property p_lit_pc;
    @(posedge CLK) disable iff (RST)
      (start && is_lit_ret) |-> ##4 (PC_LOAD && PROGRAM_COUNTER == $past(STACK_TOP_ENTRY));
  endproperty
  a_lit_pc: assert property (p_lit_pc) else $error("literal return missed load"); // RULE_02

  property p_acc_hold;
    @(posedge CLK) disable iff (RST)
      !ACC_WE |-> $stable(ACC);
  endproperty
  a_acc_hold: assert property (p_acc_hold) else $error("acc changed without write"); // RULE_03

endmodule : srx_exec

// ==== test/test_subroutine_return_exec.sv ====
// Self-checking bench for the subroutine-return execution block
`timescale 1ns/1ps
module test_subroutine_return_exec
  import srx_pkg::*;
;
  logic              CLK = 1'b0;
  logic              RST = 1'b1;
  logic [1:0]        PHASE = PHASE_Q1;
  logic              INSN_VALID = 1'b0;
  logic [INSN_W-1:0] INSN = '0;
  logic [PC_W-1:0]   STACK_TOP_ENTRY = '0;
  logic [DATA_W-1:0] ACC;
  logic              ACC_WE, PC_LOAD, STACK_POP, FETCH_FLUSH, BUSY;
  logic [PC_W-1:0]   PROGRAM_COUNTER;
  int                mismatches = 0;
  int                num_checks = 0;
  int                cycles = 0;

  srx_exec dut_u (.CLK(CLK), .RST(RST), .PHASE(PHASE), .INSN_VALID(INSN_VALID), .INSN(INSN),
    .STACK_TOP_ENTRY(STACK_TOP_ENTRY), .ACC(ACC), .ACC_WE(ACC_WE),
    .PROGRAM_COUNTER(PROGRAM_COUNTER), .PC_LOAD(PC_LOAD), .STACK_POP(STACK_POP),
    .FETCH_FLUSH(FETCH_FLUSH), .BUSY(BUSY));

  initial begin
    forever #5 CLK = ~CLK;
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Every input change lands 1 ns after the edge, so no sampling race
  task automatic step();
    @(posedge CLK);
    #1;
    PHASE = PHASE + 2'h1;
    cycles++;
    // Ceiling is several times the expected run length
    if (cycles > 400) begin
      mismatches++;
      wrap_up();
    end
  endtask : step

  task automatic align_q1();
    while (PHASE !== PHASE_Q1) step();
  endtask : align_q1

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Presents one return at Q1 and walks the eight cycles after take;
  // ghost offers a second return at the idle cycle's Q1
  task automatic do_ret(input logic [INSN_W-1:0] op, input logic [PC_W-1:0] top,
                        input logic [DATA_W-1:0] exp_acc, input logic lit, input logic ghost);
    logic pulse;
    align_q1();
    INSN_VALID = 1'b1;
    INSN = op;
    STACK_TOP_ENTRY = top;
    for (int k = 1; k <= 8; k++) begin
      step();
      INSN_VALID = 1'b0;
      pulse = (k == 4);
      check(16'(BUSY), 16'(k <= 7));
      check(16'(PC_LOAD), 16'(pulse));
      check(16'(STACK_POP), 16'(pulse));
      check(16'(FETCH_FLUSH), 16'(pulse));
      check(16'(ACC_WE), 16'(pulse & lit));
      if (k >= 4) check(16'(PROGRAM_COUNTER), 16'(top));
      if (k >= 4) check(16'(ACC), 16'(exp_acc));
      if (k == 4 && ghost) begin
        INSN_VALID = 1'b1;
        INSN = {LIT_RET_HI, 2'b00, 8'h3c};
      end
    end
  endtask : do_ret

  // An opcode that is not taken must leave BUSY, PC_LOAD, STACK_POP, FETCH_FLUSH and ACC_WE quiet
  task automatic other_op(input logic [INSN_W-1:0] op, input logic valid);
    align_q1();
    INSN_VALID = valid;
    INSN = op;
    for (int k = 1; k <= 8; k++) begin
      step();
      INSN_VALID = 1'b0;
      check(16'({BUSY, PC_LOAD, STACK_POP, FETCH_FLUSH, ACC_WE}), 16'h0000);
    end
  endtask : other_op

  initial begin
    repeat (16) step();
    RST = 1'b0;
    check(16'({BUSY, PC_LOAD, STACK_POP, FETCH_FLUSH, ACC_WE}), 16'h0000);
    check(16'(ACC), 16'(ACC_RST));
    check(16'(PROGRAM_COUNTER), 16'(PC_RST));
    do_ret({LIT_RET_HI, 2'b00, 8'ha5}, 13'h1abc, 8'ha5, 1'b1, 1'b0);
    do_ret(PLAIN_RET_OP, 13'h0123, 8'ha5, 1'b0, 1'b1);
    do_ret({LIT_RET_HI, 2'b11, 8'h5a}, 13'h1fff, 8'h5a, 1'b1, 1'b0);
    do_ret({LIT_RET_HI, 2'b01, 8'h00}, 13'h0000, 8'h00, 1'b1, 1'b0);
    other_op(14'h0009, 1'b1);
    other_op({LIT_RET_HI, 2'b00, 8'h77}, 1'b0);
    do_ret(PLAIN_RET_OP, 13'h0f0f, 8'h00, 1'b0, 1'b0);
    wrap_up();
  end
endmodule : test_subroutine_return_exec
